/* hdl/sdram_cmd_pkg.sv */
// Shared constants for the refresh and power command link.
// Assumes both ends run on one 50 MHz clock, core_clk.
package sdram_cmd_pkg;
    // -----------------------------------------------------------------
    // Geometry
    // -----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int ROW_W = 12;
    localparam int COL_W = 4;
    localparam int BANK_W = 2;
    // -----------------------------------------------------------------
    // Timing, in nanoseconds, and derived cycle counts
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int ROW_CYCLE_NS = 70;
    localparam int PRE_REFRESH_NS = 20;
    localparam int ROW_CYCLES = (ROW_CYCLE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int PRE_CYCLES = (PRE_REFRESH_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int REFRESH_ROWS = 4096;
    localparam int REFRESH_PERIOD_MS = 64;
    // 64 ms over 4096 rows, rounded down
    localparam int REFRESH_GAP_CYCLES = REFRESH_PERIOD_MS * 1000000
        / CLK_PERIOD_NS / REFRESH_ROWS;
    localparam int WAIT_W = 4;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
    // -----------------------------------------------------------------
    // Strobe encodings {ras_n, cas_n, we_n}
    // -----------------------------------------------------------------
    localparam logic [2:0] STB_NOP = 3'h7;
    localparam logic [2:0] STB_REFRESH = 3'h1;
    localparam logic [2:0] STB_WRITE = 3'h4;
    localparam logic [2:0] STB_READ = 3'h5;
    // Device operating modes
    typedef enum logic [2:0] {
        MODE_IDLE, MODE_BURST, MODE_SUSPEND, MODE_POWER_DOWN,
        MODE_SELF_REFRESH
    } dev_mode_t;
endpackage

/* hdl/sdram_link_if.sv */
// Pin bundle between the memory controller and the memory device.
// Assumes one clock shared by both ends; the data bus is resolved here.
`timescale 1ns/1ps
`default_nettype none
interface sdram_link_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [sdram_cmd_pkg::BANK_W-1:0] bank;
    logic [sdram_cmd_pkg::ROW_W-1:0] addr;
    logic [sdram_cmd_pkg::LANES-1:0] dqm;
    logic [sdram_cmd_pkg::DATA_W-1:0] dq_ctl_o;
    logic [sdram_cmd_pkg::LANES-1:0] dq_ctl_oe_n;
    logic [sdram_cmd_pkg::DATA_W-1:0] dq_dev_o;
    logic [sdram_cmd_pkg::LANES-1:0] dq_dev_oe_n;
    logic [sdram_cmd_pkg::DATA_W-1:0] dq;
    // Per lane the controller wins over the device; an undriven lane reads as zero
    always_comb
    begin
        for (int i = 0; i < sdram_cmd_pkg::LANES; i++)
        begin
            if (!dq_ctl_oe_n[i])
                dq[i*8 +: 8] = dq_ctl_o[i*8 +: 8];
            else if (!dq_dev_oe_n[i])
                dq[i*8 +: 8] = dq_dev_o[i*8 +: 8];
            else
                dq[i*8 +: 8] = 8'h00;
        end
    end
    modport ctl (output cs_n, ras_n, cas_n, we_n, cke, bank, addr, dqm,
        dq_ctl_o, dq_ctl_oe_n, input dq);
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, bank, addr, dqm,
        dq, output dq_dev_o, dq_dev_oe_n);
endinterface
`default_nettype wire

/* hdl/sdram_dev.sv */
// Device end: command decode for deselect, refresh, self-refresh,
// clock suspend and power-down, plus byte-masked write and read.
// Assumes the controller keeps its own timing rules.
//
// Contract
// - Chip select high ignores strobes and address
// - Refresh decoded: ras, cas low, we, cke high
// - One refresh per command, internal row address
// - Refresh row counter steps each refresh
// - Controller refreshes 4096 times per 64 ms; the controller spaces refreshes 782 cycles apart, about 4092 per 64 ms
// - Refresh only idle banks, cke previously high
// - Only no-ops until row cycle time passes
// - Precharge time between successive refreshes
// - Self-refresh entry: refresh code, cke low
// - Self-refresh refreshes internally, holds data forever
// - Exit self-refresh: clock, then cke high
// - No-ops for row cycle after exit
// - Refresh burst around self-refresh, recommended; the controller issues none
// - Cke low in burst freezes internal state
// - Cke low idle enters power-down, buffers off
// - Suspend or power-down under 64 ms
// - Cke high resumes clock, re-enables buffers
// - Power-down exit time, commands one cycle later
// - Write mask high discards that data word
// - Read mask low enables output, high disables
// - Row cycle time is 60 or 70 ns
// - Precharge to refresh is 15 or 20 ns
`timescale 1ns/1ps
`default_nettype none
module sdram_dev
(
    input wire logic core_clk,
    input wire logic sys_rst,
    sdram_link_if.dev link,
    output logic [sdram_cmd_pkg::ROW_W-1:0] refresh_row,
    output logic [sdram_cmd_pkg::ROW_W-1:0] self_refresh_count,
    output logic powered_down,
    output logic in_self_refresh,
    output logic [sdram_cmd_pkg::DATA_W-1:0] peek_data
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    localparam int DEPTH = 1 << sdram_cmd_pkg::COL_W;
    sdram_cmd_pkg::dev_mode_t mode_ff;
    sdram_cmd_pkg::dev_mode_t nxt_mode;
    logic [sdram_cmd_pkg::ROW_W-1:0] row_ff;
    logic [sdram_cmd_pkg::ROW_W-1:0] self_cnt_ff;
    logic [sdram_cmd_pkg::WAIT_W-1:0] self_tmr_ff;
    logic [sdram_cmd_pkg::COL_W-1:0] col_ff;
    logic [sdram_cmd_pkg::DATA_W-1:0] mem_ff [DEPTH];
    logic [sdram_cmd_pkg::DATA_W-1:0] dout_ff;
    logic [sdram_cmd_pkg::LANES-1:0] oe_n_ff;
    logic pd_ff;
    logic sr_ff;
    logic rd_ff;
    logic wr_ff;
    logic cke_prev_ff;
    logic [sdram_cmd_pkg::DATA_W-1:0] peek_ff;
    // -----------------------------------------------------------------
    // Command decode
    // -----------------------------------------------------------------
    wire logic [2:0] stb = {link.ras_n, link.cas_n, link.we_n};
    // Deselect hides the strobes and address; cke still acts
    wire logic selected = !link.cs_n;
    wire logic refresh_code = selected
        && stb == sdram_cmd_pkg::STB_REFRESH;
    wire logic is_refresh = refresh_code && link.cke
        && cke_prev_ff && mode_ff == sdram_cmd_pkg::MODE_IDLE;
    wire logic is_self_entry = refresh_code && !link.cke
        && cke_prev_ff && mode_ff == sdram_cmd_pkg::MODE_IDLE;
    wire logic is_write = selected && link.cke
        && stb == sdram_cmd_pkg::STB_WRITE;
    wire logic is_read = selected && link.cke
        && stb == sdram_cmd_pkg::STB_READ;
    wire logic clock_live = mode_ff != sdram_cmd_pkg::MODE_SUSPEND
        && mode_ff != sdram_cmd_pkg::MODE_POWER_DOWN
        && mode_ff != sdram_cmd_pkg::MODE_SELF_REFRESH;
    wire logic [sdram_cmd_pkg::ROW_W-1:0] row_step =
        row_ff + sdram_cmd_pkg::ROW_W'(1);
    wire logic [sdram_cmd_pkg::COL_W-1:0] col_step =
        col_ff + sdram_cmd_pkg::COL_W'(1);
    wire logic [sdram_cmd_pkg::COL_W-1:0] wr_col =
        is_write ? link.addr[sdram_cmd_pkg::COL_W-1:0] : col_ff;
    wire logic do_write = clock_live && (is_write || wr_ff);

    // -----------------------------------------------------------------
    // Mode transitions
    // -----------------------------------------------------------------
    always_comb
    begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            sdram_cmd_pkg::MODE_IDLE:
                if (is_self_entry)
                    nxt_mode = sdram_cmd_pkg::MODE_SELF_REFRESH;
                else if (!link.cke)
                    nxt_mode = sdram_cmd_pkg::MODE_POWER_DOWN;
                else if (is_write || is_read)
                    nxt_mode = sdram_cmd_pkg::MODE_BURST;
            sdram_cmd_pkg::MODE_BURST:
                if (!link.cke)
                    nxt_mode = sdram_cmd_pkg::MODE_SUSPEND;
                else if (selected && stb == sdram_cmd_pkg::STB_NOP
                    && !rd_ff && !wr_ff)
                    nxt_mode = sdram_cmd_pkg::MODE_IDLE;
            sdram_cmd_pkg::MODE_SUSPEND:
                if (link.cke)
                    nxt_mode = sdram_cmd_pkg::MODE_BURST;
            sdram_cmd_pkg::MODE_POWER_DOWN:
                if (link.cke)
                    nxt_mode = sdram_cmd_pkg::MODE_IDLE;
            sdram_cmd_pkg::MODE_SELF_REFRESH:
                if (link.cke)
                    nxt_mode = sdram_cmd_pkg::MODE_IDLE;
        endcase
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_ff <= sdram_cmd_pkg::MODE_IDLE;
            cke_prev_ff <= 1'b0;
            pd_ff <= 1'b0;
            sr_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            cke_prev_ff <= link.cke;
            pd_ff <= nxt_mode == sdram_cmd_pkg::MODE_POWER_DOWN;
            sr_ff <= nxt_mode == sdram_cmd_pkg::MODE_SELF_REFRESH;
        end
    end

    // Refresh rows come from the counter, never the address
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            row_ff <= '0;
        else if (is_refresh)
            row_ff <= row_step;
        else if (mode_ff == sdram_cmd_pkg::MODE_SELF_REFRESH
            && self_tmr_ff == sdram_cmd_pkg::WAIT_ZERO)
            row_ff <= row_step;
    end

    // Timer paces self-refresh rows at the row cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            self_tmr_ff <= sdram_cmd_pkg::WAIT_ZERO;
            self_cnt_ff <= '0;
        end
        else if (mode_ff == sdram_cmd_pkg::MODE_SELF_REFRESH)
        begin
            if (self_tmr_ff == sdram_cmd_pkg::WAIT_ZERO)
            begin
                self_tmr_ff <= sdram_cmd_pkg::WAIT_W'(
                    sdram_cmd_pkg::ROW_CYCLES - 1);
                self_cnt_ff <= self_cnt_ff + sdram_cmd_pkg::ROW_W'(1);
            end
            else
                self_tmr_ff <= self_tmr_ff - sdram_cmd_pkg::WAIT_ONE;
        end
        else
            self_tmr_ff <= sdram_cmd_pkg::WAIT_ZERO;
    end

    // Burst column and data; all held while the clock is masked
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            col_ff <= '0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
        end
        else if (clock_live)
        begin
            rd_ff <= is_read || (rd_ff && !is_write
                && !(selected && stb == sdram_cmd_pkg::STB_NOP));
            wr_ff <= is_write || (wr_ff && !is_read
                && !(selected && stb == sdram_cmd_pkg::STB_NOP));
            if (is_write || is_read)
                col_ff <= link.addr[sdram_cmd_pkg::COL_W-1:0] + 1'b1;
            else if (rd_ff || wr_ff)
                col_ff <= col_step;
        end
    end

    genvar g;
    generate
        for (g = 0; g < sdram_cmd_pkg::LANES; g++)
        begin : lane
            // Masked lanes keep their old byte
            always_ff @(posedge core_clk)
            begin
                if (do_write && !link.dqm[g])
                    mem_ff[wr_col][g*8 +: 8] <= link.dq[g*8 +: 8];
            end
            // Lane drives on unmasked reads; frozen in suspend
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                    oe_n_ff[g] <= 1'b1;
                else if (mode_ff != sdram_cmd_pkg::MODE_SUSPEND)
                    oe_n_ff[g] <= !(clock_live && (is_read || rd_ff)
                        && !link.dqm[g]);
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            dout_ff <= '0;
            peek_ff <= '0;
        end
        else
        begin
            if (clock_live)
                dout_ff <= mem_ff[is_read
                    ? link.addr[sdram_cmd_pkg::COL_W-1:0] : col_ff];
            peek_ff <= mem_ff[link.addr[sdram_cmd_pkg::COL_W-1:0]];
        end
    end

    assign link.dq_dev_o = dout_ff;
    assign link.dq_dev_oe_n = oe_n_ff;
    assign refresh_row = row_ff;
    assign self_refresh_count = self_cnt_ff;
    assign powered_down = pd_ff;
    assign in_self_refresh = sr_ff;
    assign peek_data = peek_ff;
endmodule
`default_nettype wire

/* hdl/sdram_ctl.sv */
// Controller end: issues refresh, self-refresh and power-down commands
// and paces them. Assumes the device end decodes on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctl
#(
    parameter int REFRESH_GAP = sdram_cmd_pkg::REFRESH_GAP_CYCLES
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    sdram_link_if.ctl link,
    input wire logic sleep_req,
    input wire logic nap_req,
    output logic busy,
    output logic [15:0] refresh_count
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_REFRESH_WAIT, ST_PRE_WAIT, ST_SELF, ST_EXIT_WAIT,
        ST_NAP, ST_NAP_EXIT
    } ctl_state_t;
    ctl_state_t st_ff;
    logic [sdram_cmd_pkg::WAIT_W-1:0] wait_ff;
    logic [15:0] gap_ff;
    logic [15:0] cnt_ff;
    logic cke_ff;
    logic cs_n_ff;
    logic [2:0] stb_ff;
    logic busy_ff;
    // -----------------------------------------------------------------
    // Decisions
    // -----------------------------------------------------------------
    wire logic due = gap_ff == 16'h0000;
    wire logic wait_done = wait_ff == sdram_cmd_pkg::WAIT_ZERO;
    // Refresh only from idle with cke already high
    wire logic go_refresh = st_ff == ST_IDLE && cke_ff && due;
    wire logic go_self = st_ff == ST_IDLE && cke_ff && sleep_req && !due;
    wire logic go_nap = st_ff == ST_IDLE && cke_ff && nap_req
        && !sleep_req && !due;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_ff <= ST_IDLE;
            wait_ff <= sdram_cmd_pkg::WAIT_ZERO;
            gap_ff <= 16'(REFRESH_GAP);
            cnt_ff <= 16'h0000;
            cke_ff <= 1'b1;
            cs_n_ff <= 1'b1;
            stb_ff <= sdram_cmd_pkg::STB_NOP;
            busy_ff <= 1'b0;
        end
        else
        begin
            cs_n_ff <= !go_refresh && !go_self;
            stb_ff <= (go_refresh || go_self)
                ? sdram_cmd_pkg::STB_REFRESH : sdram_cmd_pkg::STB_NOP;
            busy_ff <= st_ff != ST_IDLE || go_refresh;
            if (!wait_done)
                wait_ff <= wait_ff - sdram_cmd_pkg::WAIT_ONE;
            // Self-refresh keeps the rows alive; nap must stay short
            if (go_refresh || st_ff == ST_SELF)
                gap_ff <= 16'(REFRESH_GAP);
            else if (!due)
                gap_ff <= gap_ff - 16'h0001;
            unique case (st_ff)
                ST_IDLE:
                    if (go_refresh)
                    begin
                        st_ff <= ST_REFRESH_WAIT;
                        cnt_ff <= cnt_ff + 16'h0001;
                        wait_ff <= sdram_cmd_pkg::WAIT_W'(
                            sdram_cmd_pkg::ROW_CYCLES);
                    end
                    else if (go_self)
                    begin
                        st_ff <= ST_SELF;
                        cke_ff <= 1'b0;
                    end
                    else if (go_nap)
                    begin
                        st_ff <= ST_NAP;
                        cke_ff <= 1'b0;
                    end
                ST_REFRESH_WAIT:
                    if (wait_done)
                    begin
                        st_ff <= ST_PRE_WAIT;
                        wait_ff <= sdram_cmd_pkg::WAIT_W'(
                            sdram_cmd_pkg::PRE_CYCLES);
                    end
                ST_PRE_WAIT:
                    if (wait_done)
                        st_ff <= ST_IDLE;
                ST_SELF:
                    if (!sleep_req)
                    begin
                        st_ff <= ST_EXIT_WAIT;
                        cke_ff <= 1'b1;
                        wait_ff <= sdram_cmd_pkg::WAIT_W'(
                            sdram_cmd_pkg::ROW_CYCLES);
                    end
                ST_EXIT_WAIT:
                    if (wait_done)
                        st_ff <= ST_IDLE;
                ST_NAP:
                    // Leave before the next refresh falls due
                    if (!nap_req || gap_ff <= 16'h0002)
                    begin
                        st_ff <= ST_NAP_EXIT;
                        cke_ff <= 1'b1;
                        wait_ff <= sdram_cmd_pkg::WAIT_ONE;
                    end
                ST_NAP_EXIT:
                    if (wait_done)
                        st_ff <= ST_IDLE;
                default:
                    st_ff <= ST_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.ras_n = stb_ff[2];
    assign link.cas_n = stb_ff[1];
    assign link.we_n = stb_ff[0];
    assign link.cke = cke_ff;
    assign link.bank = '0;
    assign link.addr = '0;
    assign link.dqm = '1;
    assign link.dq_ctl_o = '0;
    assign link.dq_ctl_oe_n = '1;
    assign busy = busy_ff;
    assign refresh_count = cnt_ff;
endmodule
`default_nettype wire

/* testbench/sdram_link_monitor.sv */
// Concurrent checks on the pins between controller and device.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sdram_link_monitor
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [3:0] dq_dev_oe_n,
    input wire logic [11:0] refresh_row,
    input wire logic [11:0] self_refresh_count,
    input wire logic powered_down,
    input wire logic in_self_refresh
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic [2:0] stb = {ras_n, cas_n, we_n};
    wire logic sel_ref = !cs_n && stb == sdram_cmd_pkg::STB_REFRESH;
    wire logic awake = !in_self_refresh && !powered_down;
    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    a_refresh_row_step: assert property (sel_ref && cke && $past(cke)
        && awake && !$past(sys_rst) |=> refresh_row == $past(refresh_row)
        + 12'h001) else $error("row not stepped");
    a_deselect_ignored: assert property (cs_n && cke && awake
        && !$past(in_self_refresh) |=> $stable(refresh_row))
        else $error("deselect changed row");
    a_self_entry: assert property (sel_ref && !cke && $past(cke)
        && awake && !$past(sys_rst) |=> in_self_refresh)
        else $error("self-refresh not entered");
    a_self_hold: assert property (in_self_refresh && !cke
        |=> in_self_refresh) else $error("sleep left, cke low");
    a_self_steps: assert property (in_self_refresh [*6]
        |-> self_refresh_count != $past(self_refresh_count, 4))
        else $error("no internal refresh");
    a_pd_entry: assert property (!cke && $past(cke) && !sel_ref
        && awake && !$past(sys_rst) |=> powered_down)
        else $error("power-down not entered");
    a_pd_buffers_off: assert property (powered_down
        |-> dq_dev_oe_n == 4'hF) else $error("output on in nap");
    a_pd_exit_resume: assert property (powered_down && cke
        |=> !powered_down) else $error("power-down not left");
    a_refresh_then_nop: assert property (sel_ref && cke && awake
        |=> (cs_n || stb == sdram_cmd_pkg::STB_NOP) [*4])
        else $error("command during refresh");
    c_refresh: cover property (sel_ref && cke && awake);
    c_self_in: cover property ($rose(in_self_refresh));
    c_self_out: cover property ($fell(in_self_refresh));
    c_nap: cover property ($rose(powered_down));
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench: controller and device joined on link_a, and a
// second device on link_b driven directly by the bench.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int GAP = 20;
    localparam int ROWC = sdram_cmd_pkg::ROW_CYCLES;
    localparam int PREC = sdram_cmd_pkg::PRE_CYCLES;
    localparam logic [2:0] REF = sdram_cmd_pkg::STB_REFRESH;
    localparam logic [2:0] NOP = sdram_cmd_pkg::STB_NOP;
    logic core_clk, sys_rst, sleep_req, nap_req, busy;
    logic [15:0] refresh_count;
    logic [11:0] row_a, srs_a, row_b, srs_b, r0;
    logic pd_a, sr_a, pd_b, sr_b;
    logic [31:0] peek_b, seed, d, exp_d;
    logic [3:0] col, m;
    int errors, n_compared, n_ref, since_ref, quiet_left, base, hold;
    logic [31:0] mem [16];
    sdram_link_if link_a();
    sdram_link_if link_b();
    sdram_ctl #(.REFRESH_GAP(GAP)) u_sdram_ctl (.core_clk(core_clk),
        .sys_rst(sys_rst), .link(link_a.ctl), .sleep_req(sleep_req),
        .nap_req(nap_req), .busy(busy), .refresh_count(refresh_count));
    sdram_dev u_sdram_dev (.core_clk(core_clk), .sys_rst(sys_rst),
        .link(link_a.dev), .refresh_row(row_a), .self_refresh_count(srs_a),
        .powered_down(pd_a), .in_self_refresh(sr_a), .peek_data());
    sdram_dev u_sdram_dev_b (.core_clk(core_clk), .sys_rst(sys_rst),
        .link(link_b.dev), .refresh_row(row_b), .self_refresh_count(srs_b),
        .powered_down(pd_b), .in_self_refresh(sr_b), .peek_data(peek_b));
    sdram_link_monitor u_sdram_link_monitor (.core_clk(core_clk),
        .sys_rst(sys_rst), .cs_n(link_a.cs_n), .ras_n(link_a.ras_n),
        .cas_n(link_a.cas_n), .we_n(link_a.we_n), .cke(link_a.cke),
        .dq_dev_oe_n(link_a.dq_dev_oe_n), .refresh_row(row_a),
        .self_refresh_count(srs_a), .powered_down(pd_a),
        .in_self_refresh(sr_a));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask
    // One cycle of pins on the bench-driven link
    task automatic drive_b(input logic cs, input logic [2:0] s,
        input logic ck, input logic [3:0] c, input logic [3:0] mk,
        input logic [31:0] dv, input logic [3:0] oe);
        @(posedge core_clk);
        link_b.cs_n <= cs;
        {link_b.ras_n, link_b.cas_n, link_b.we_n} <= s;
        link_b.cke <= ck;
        link_b.addr <= {8'h00, c};
        link_b.dqm <= mk;
        link_b.dq_ctl_o <= dv;
        link_b.dq_ctl_oe_n <= oe;
    endtask
    task automatic print_verdict();
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // Wire watcher on the controller link
    // -----------------------------------------------------------------
    wire logic [2:0] stb_a = {link_a.ras_n, link_a.cas_n, link_a.we_n};
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            n_ref <= 0;
            since_ref <= 99;
            quiet_left <= 0;
        end
        else
        begin
            since_ref <= since_ref + 1;
            if (quiet_left > 0)
            begin
                quiet_left <= quiet_left - 1;
                check(link_a.cs_n || stb_a == NOP, "command in wait");
            end
            if (!link_a.cs_n && stb_a == REF && link_a.cke)
            begin
                n_ref <= n_ref + 1;
                since_ref <= 1;
                quiet_left <= ROWC;
                check(since_ref > ROWC + PREC, "refresh too close");
            end
            if (sr_a && link_a.cke)
                quiet_left <= ROWC;
        end
    end
    initial
    begin
        tick(5000);
        errors++;
        print_verdict();
    end
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial
    begin
        errors = 0;
        n_compared = 0;
        seed = 32'h501BD539;
        sys_rst = 1'b1;
        sleep_req = 1'b0;
        nap_req = 1'b0;
        link_b.bank = 2'h0;
        drive_b(1'b1, NOP, 1'b1, 4'h0, 4'hF, 32'h0, 4'hF);
        repeat (15) @(posedge core_clk);
        sys_rst <= 1'b0;
        tick(2);
        // Paced refresh from the controller
        base = n_ref;
        r0 = row_a;
        tick(200);
        check(n_ref - base >= 200 / (GAP + 8), "too few refreshes");
        check(refresh_count === 16'(n_ref), "refresh count");
        check(row_a - r0 === 12'(n_ref - base), "refresh row");
        // Power-down, first held past a refresh interval
        for (int i = 0; i < 3; i++)
        begin
            hold = (i == 0) ? 3 * GAP : int'(xs() % 8) + 2;
            base = n_ref;
            @(posedge core_clk);
            nap_req <= 1'b1;
            for (int k = 0; k < 40 && pd_a !== 1'b1; k++)
                tick(1);
            check(pd_a && !link_a.cke && busy, "no nap");
            tick(hold);
            if (i == 0)
                check(n_ref > base, "nap starved refresh");
            @(posedge core_clk);
            nap_req <= 1'b0;
            for (int k = 0; k < 40 && pd_a !== 1'b0; k++)
                tick(1);
            check(pd_a === 1'b0, "nap not left");
        end
        // Self-refresh with internal stepping
        @(posedge core_clk);
        sleep_req <= 1'b1;
        for (int k = 0; k < 60 && sr_a !== 1'b1; k++)
            tick(1);
        check(sr_a === 1'b1 && link_a.cke === 1'b0, "no sleep");
        r0 = srs_a;
        tick(40);
        r0 = srs_a - r0;
        check(r0 >= 12'd9 && r0 <= 12'd11, "self steps");
        @(posedge core_clk);
        sleep_req <= 1'b0;
        for (int k = 0; k < 60 && sr_a !== 1'b0; k++)
            tick(1);
        check(sr_a === 1'b0, "sleep not left");
        base = n_ref;
        tick(3 * GAP);
        check(n_ref > base, "refresh after sleep");
        // Deselect and direct refresh on the bench link
        r0 = row_b;
        repeat (4)
            drive_b(1'b1, REF, 1'b1, 4'(xs()), 4'hF, 32'h0, 4'hF);
        drive_b(1'b1, NOP, 1'b1, 4'h0, 4'hF, 32'h0, 4'hF);
        tick(2);
        check(row_b === r0, "deselect decoded");
        for (int i = 1; i <= 3; i++)
        begin
            drive_b(1'b0, REF, 1'b1, 4'(xs()), 4'hF, 32'h0, 4'hF);
            drive_b(1'b1, NOP, 1'b1, 4'h0, 4'hF, 32'h0, 4'hF);
            tick(ROWC + PREC);
            check(row_b === r0 + 12'(i), "direct refresh");
        end
        drive_b(1'b0, REF, 1'b0, 4'h0, 4'hF, 32'h0, 4'hF);
        repeat (8)
            drive_b(1'b0, 3'(xs()), 1'b0, 4'(xs()), 4'(xs()), xs(),
                4'hF);
        check(sr_b === 1'b1 && pd_b === 1'b0, "direct sleep");
        drive_b(1'b1, NOP, 1'b1, 4'h0, 4'hF, 32'h0, 4'hF);
        tick(ROWC + 1);
        check(sr_b === 1'b0, "direct wake");
        // Masked writes and reads, every column preset first
        for (int i = 0; i < 24; i++)
        begin
            col = (i < 16) ? 4'(i) : 4'(xs());
            d = xs();
            m = (i < 16) ? 4'h0 : 4'(xs());
            drive_b(1'b0, sdram_cmd_pkg::STB_WRITE, 1'b1, col, m, d, 4'h0);
            for (int l = 0; l < 4; l++)
                if (!m[l])
                    mem[col][l*8 +: 8] = d[l*8 +: 8];
            drive_b(1'b0, NOP, 1'b1, col, 4'hF, d, 4'hF);
            tick(2);
            check(peek_b === mem[col], "write mask");
            m = 4'(xs());
            drive_b(1'b0, sdram_cmd_pkg::STB_READ, 1'b1, col, m, 32'h0, 4'hF);
            drive_b(1'b1, NOP, 1'b1, col, m, 32'h0, 4'hF);
            #1;
            for (int l = 0; l < 4; l++)
                exp_d[l*8 +: 8] = m[l] ? 8'h00 : mem[col][l*8 +: 8];
            check(link_b.dq_dev_oe_n === m, "read oe");
            check(link_b.dq === exp_d, "read data");
            repeat (3)
                drive_b(1'b1, NOP, 1'b0, col, m, 32'h0, 4'hF);
            #1;
            check(link_b.dq_dev_oe_n === m && pd_b === 1'b0, "suspend");
            repeat (2)
                drive_b(1'b0, NOP, 1'b1, col, 4'hF, 32'h0, 4'hF);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
